/* File: serial_port_pin_mux_pkg.sv */
// constants for the serial port pin multiplexer
package serial_port_pin_mux_pkg;
    localparam int unsigned ADDR_W   = 16;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned IDX_W    = 14;
    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] MODE_CTRL_IDX = 14'h2015;
    localparam logic [IDX_W-1:0] CORE_SYS_IDX  = 14'h3fff;
    localparam logic [IDX_W-1:0] PIN_SEL_IDX   = 14'h2049;
    localparam logic [IDX_W-1:0] RX_GPIO_IDX   = 14'h2050;
    // register widths
    localparam int unsigned MODE_W   = 9;
    localparam int unsigned SYS_W    = 16;
    localparam int unsigned PSEL_W   = 8;
    localparam int unsigned GPIO_W   = 4;
    // reset values
    localparam logic [MODE_W-1:0] MODE_RST = 9'h000;
    localparam logic [SYS_W-1:0]  SYS_RST  = 16'h0000;
    localparam logic [PSEL_W-1:0] PSEL_RST = 8'h00;
    localparam logic [GPIO_W-1:0] GPIO_RST = 4'h0;
    // field positions
    localparam int unsigned RX_SEL_BIT   = 4;
    localparam int unsigned UART_BIT     = 5;
    localparam int unsigned ALT_BIT      = 10;
    localparam int unsigned SCLK_PIO_BIT = 3;
    // receive gpio register: drive values [1:0], enables [3:2]
    localparam int unsigned GPIO_OUT_A   = 0;
    localparam int unsigned GPIO_OUT_B   = 1;
    localparam int unsigned GPIO_EN_A    = 2;
    localparam int unsigned GPIO_EN_B    = 3;
    localparam int unsigned GPIO_LVL_LSB = 4;
    // synchroniser lanes
    localparam int unsigned SYNC_W       = 5;
    localparam int unsigned S_RX_A       = 0;
    localparam int unsigned S_RX_B       = 1;
    localparam int unsigned S_RFS        = 2;
    localparam int unsigned S_TFS        = 3;
    localparam int unsigned S_SCLK       = 4;
endpackage : serial_port_pin_mux_pkg

/* File: pin_sync_if.sv */
// raw pin levels and their synchronised copies
`timescale 1ns/1ns
interface pin_sync_if #(parameter int unsigned W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport sync_side (input raw, output sync);
    modport user_side (output raw, input sync);
endinterface : pin_sync_if

/* File: pin_sync_bank.sv */
// two flip-flop synchronisers, one per pin lane
`timescale 1ns/1ns
module pin_sync_bank #(
    parameter int unsigned W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    pin_sync_if.sync_side     pins
);
    for (genvar i = 0; i < W; i++) begin : g_lane
        logic meta_q;
        logic meta_d;
        logic sync_q;
        logic sync_d;
        always_comb begin
            meta_d = pins.raw[i];
            sync_d = meta_q;
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                meta_q <= 1'b0;
                sync_q <= 1'b0;
            end else begin
                meta_q <= meta_d;
                sync_q <= sync_d;
            end
        end
        assign pins.sync[i] = sync_q;
    end
endmodule : pin_sync_bank

/* File: serial_port_pin_mux.sv */
// pin multiplexer around the first serial port, with apb registers
//
// Overview of operation
// - receive-select bit picks second receive pin when set, first when clear
// - uart-mode bit joins internal receive data to receive frame sync
// - uart-mode bit drives core flag output one onto shared frame sync pin
// - one core system control bit selects the alternate pin configuration
// - alternate mode: selected receive pin is flag input, transmit is flag out
// - alternate mode: frame sync pins become core interrupts zero and one
// - serial clock pin keeps serving the serial port in alternate mode
// - unselected receive pin works as an ordinary general-purpose line
`timescale 1ns/1ns
module serial_port_pin_mux
    import serial_port_pin_mux_pkg::*;
(
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic [serial_port_pin_mux_pkg::ADDR_W-1:0] paddr,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [serial_port_pin_mux_pkg::DATA_W-1:0] pwdata,
    output logic [serial_port_pin_mux_pkg::DATA_W-1:0]      prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       first_rx_in,
    output logic                            first_rx_out,
    output logic                            first_rx_oe_n,
    input  wire logic                       second_rx_in,
    output logic                            second_rx_out,
    output logic                            second_rx_oe_n,
    input  wire logic                       frame_sync_in,
    output logic                            frame_sync_out,
    output logic                            frame_sync_oe_n,
    input  wire logic                       tx_frame_sync_in,
    input  wire logic                       serial_clock_in,
    output logic                            transmit_data_out,
    input  wire logic                       sp_tx_data,
    input  wire logic                       core_flag_one,
    input  wire logic                       core_flag_out,
    output logic                            sp_rx_data,
    output logic                            sp_rx_frame_sync,
    output logic                            sp_tx_frame_sync,
    output logic                            sp_sclk_rise,
    output logic                            sp_sclk_fall,
    output logic                            flag_input,
    output logic                            core_core_interrupt_zero_n,
    output logic                            core_core_interrupt_one_n
);
    import serial_port_pin_mux_pkg::*;

    pin_sync_if #(.W(SYNC_W)) pins ();

    pin_sync_bank #(.W(SYNC_W)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pins    (pins.sync_side)
    );

    assign pins.raw = {serial_clock_in, tx_frame_sync_in, frame_sync_in,
                       second_rx_in, first_rx_in};

    // register state
    logic [MODE_W-1:0] mode_q,  mode_d;
    logic [SYS_W-1:0]  sys_q,   sys_d;
    logic [PSEL_W-1:0] psel_q,  psel_d;
    logic [GPIO_W-1:0] gpio_q,  gpio_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic              ready_q, ready_d;
    logic              err_q,   err_d;

    logic [IDX_W-1:0]  idx_w;
    logic              hit_w;
    logic              wr_w;
    logic              wr_sys_w;
    logic              alt_wr_w;

    assign idx_w    = paddr[ADDR_W-1:2];
    assign hit_w    = (idx_w == MODE_CTRL_IDX) || (idx_w == CORE_SYS_IDX) ||
                      (idx_w == PIN_SEL_IDX) || (idx_w == RX_GPIO_IDX);
    // writes land in the access cycle in which pready is high
    assign wr_w     = psel && penable && pwrite && ready_q && hit_w;
    assign wr_sys_w = wr_w && (idx_w == CORE_SYS_IDX);
    assign alt_wr_w = pwdata[ALT_BIT];

    always_comb begin
        mode_d  = mode_q;
        sys_d   = sys_q;
        psel_d  = psel_q;
        gpio_d  = gpio_q;
        rdata_d = rdata_q;
        // answer one cycle after setup, so access phase has no wait
        ready_d = psel && !penable;
        err_d   = psel && !penable && !hit_w;
        if (psel && !penable) begin
            rdata_d = '0;
            if (!pwrite) begin
                case (idx_w)
                    MODE_CTRL_IDX: rdata_d[MODE_W-1:0] = mode_q;
                    CORE_SYS_IDX:  rdata_d[SYS_W-1:0]  = sys_q;
                    PIN_SEL_IDX:   rdata_d[PSEL_W-1:0] = psel_q;
                    RX_GPIO_IDX: begin
                        rdata_d[GPIO_W-1:0] = gpio_q;
                        rdata_d[GPIO_LVL_LSB+1:GPIO_LVL_LSB] =
                            {pins.sync[S_RX_B], pins.sync[S_RX_A]};
                    end
                    default:       rdata_d = '0;
                endcase
            end
        end
        if (wr_w) begin
            case (idx_w)
                MODE_CTRL_IDX: mode_d = pwdata[MODE_W-1:0];
                CORE_SYS_IDX:  sys_d  = pwdata[SYS_W-1:0];
                PIN_SEL_IDX:   psel_d = pwdata[PSEL_W-1:0];
                RX_GPIO_IDX:   gpio_d = pwdata[GPIO_W-1:0];
                default:       mode_d = mode_q;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q  <= MODE_RST;
            sys_q   <= SYS_RST;
            psel_q  <= PSEL_RST;
            gpio_q  <= GPIO_RST;
            rdata_q <= '0;
            ready_q <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            mode_q  <= mode_d;
            sys_q   <= sys_d;
            psel_q  <= psel_d;
            gpio_q  <= gpio_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q   <= err_d;
        end
    end

    assign prdata  = rdata_q;
    assign pready  = ready_q;
    assign pslverr = err_q;

    // pin multiplexing
    logic rx_sel_w, uart_w, alt_w, sclk_ext_w, rx_pick_w;
    assign rx_sel_w   = mode_q[RX_SEL_BIT];
    assign uart_w     = mode_q[UART_BIT];
    assign alt_w      = sys_q[ALT_BIT];
    assign sclk_ext_w = !psel_q[SCLK_PIO_BIT];
    assign rx_pick_w  = rx_sel_w ? pins.sync[S_RX_B]
                                 : pins.sync[S_RX_A];

    logic sclk_prev_q, sclk_prev_d;
    logic rx_q, rx_d, rfs_q, rfs_d, tfs_q, tfs_d;
    logic rise_q, rise_d, fall_q, fall_d;
    logic fi_q, fi_d, core_interrupt_zero_q, core_interrupt_zero_d, core_interrupt_one_q, core_interrupt_one_d;
    logic txo_q, txo_d, fso_q, fso_d, fsoe_q, fsoe_d;
    logic ao_q, ao_d, aoe_q, aoe_d, bo_q, bo_d, boe_q, boe_d;

    always_comb begin
        sclk_prev_d = pins.sync[S_SCLK];
        // clock edges reach the port in both configurations
        rise_d = sclk_ext_w && pins.sync[S_SCLK] && !sclk_prev_q;
        fall_d = sclk_ext_w && !pins.sync[S_SCLK] && sclk_prev_q;
        rx_d   = alt_w ? 1'b0 : rx_pick_w;
        rfs_d  = alt_w ? 1'b0
               : (uart_w ? rx_pick_w : pins.sync[S_RFS]);
        tfs_d  = alt_w ? 1'b0 : pins.sync[S_TFS];
        fi_d   = alt_w ? rx_pick_w : 1'b0;
        txo_d  = alt_w ? core_flag_out : sp_tx_data;
        core_interrupt_zero_d = alt_w ? pins.sync[S_RFS] : 1'b1;
        core_interrupt_one_d = alt_w ? pins.sync[S_TFS] : 1'b1;
        fso_d  = uart_w ? core_flag_one : 1'b0;
        fsoe_d = !uart_w;
        // only the receive pin not feeding the port may drive
        ao_d   = gpio_q[GPIO_OUT_A];
        bo_d   = gpio_q[GPIO_OUT_B];
        aoe_d  = !(rx_sel_w && gpio_q[GPIO_EN_A]);
        boe_d  = !(!rx_sel_w && gpio_q[GPIO_EN_B]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_prev_q <= 1'b0;
            rx_q   <= 1'b0;
            rfs_q  <= 1'b0;
            tfs_q  <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
            fi_q   <= 1'b0;
            txo_q  <= 1'b0;
            core_interrupt_zero_q <= 1'b1;
            core_interrupt_one_q <= 1'b1;
            fso_q  <= 1'b0;
            fsoe_q <= 1'b1;
            ao_q   <= 1'b0;
            bo_q   <= 1'b0;
            aoe_q  <= 1'b1;
            boe_q  <= 1'b1;
        end else begin
            sclk_prev_q <= sclk_prev_d;
            rx_q   <= rx_d;
            rfs_q  <= rfs_d;
            tfs_q  <= tfs_d;
            rise_q <= rise_d;
            fall_q <= fall_d;
            fi_q   <= fi_d;
            txo_q  <= txo_d;
            core_interrupt_zero_q <= core_interrupt_zero_d;
            core_interrupt_one_q <= core_interrupt_one_d;
            fso_q  <= fso_d;
            fsoe_q <= fsoe_d;
            ao_q   <= ao_d;
            bo_q   <= bo_d;
            aoe_q  <= aoe_d;
            boe_q  <= boe_d;
        end
    end

    assign sp_rx_data        = rx_q;
    assign sp_rx_frame_sync  = rfs_q;
    assign sp_tx_frame_sync  = tfs_q;
    assign sp_sclk_rise      = rise_q;
    assign sp_sclk_fall      = fall_q;
    assign flag_input        = fi_q;
    assign transmit_data_out = txo_q;
    assign core_core_interrupt_zero_n       = core_interrupt_zero_q;
    assign core_core_interrupt_one_n       = core_interrupt_one_q;
    assign frame_sync_out    = fso_q;
    assign frame_sync_oe_n   = fsoe_q;
    assign first_rx_out      = ao_q;
    assign first_rx_oe_n     = aoe_q;
    assign second_rx_out     = bo_q;
    assign second_rx_oe_n    = boe_q;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence sclk_rise_seq;
        !pins.sync[S_SCLK] ##1 (pins.sync[S_SCLK] && sclk_ext_w);
    endsequence

    rx_select_a: assert property (!alt_w |=> rx_q == $past(rx_pick_w))
        else $error("receive data not from selected pin");
    uart_join_a: assert property ((uart_w && !alt_w) |=>
        (rfs_q == rx_q))
        else $error("frame sync not joined to receive data");
    flag_drive_a: assert property (uart_w |=>
        (!fsoe_q && fso_q == $past(core_flag_one)))
        else $error("flag one not driven on frame sync pin");
    alt_select_a: assert property (wr_sys_w |=>
        alt_w == $past(alt_wr_w))
        else $error("alternate bit did not follow write");
    flag_io_a: assert property (alt_w |=> (fi_q == $past(rx_pick_w) &&
        txo_q == $past(core_flag_out) && !rx_q))
        else $error("flag pins not routed in alternate mode");
    irq_route_a: assert property (alt_w |=> (core_interrupt_zero_q ==
        $past(pins.sync[S_RFS]) && core_interrupt_one_q == $past(pins.sync[S_TFS])))
        else $error("frame sync pins not routed to interrupts");
    sclk_edge_a: assert property (sclk_rise_seq |=> rise_q ##1 !rise_q)
        else $error("serial clock rise not passed once");
    gpio_free_a: assert property (!rx_sel_w |=> aoe_q)
        else $error("selected receive pin is being driven");
    reset_clear_a: assert property (@(posedge pclk) disable iff (1'b0)
        !presetn |-> (!rx_sel_w && !uart_w && !alt_w))
        else $error("mode bits not cleared in reset");
endmodule : serial_port_pin_mux

/* File: serial_link_peer.sv */
// far-side serial peer that drives the port's pin levels
`timescale 1ns/1ns
module serial_link_peer (
    input  wire logic pclk
);
    logic rx_a = 1'b0;
    logic rx_b = 1'b0;
    logic rfs  = 1'b0;
    logic tfs  = 1'b0;
    logic sclk = 1'b0;

    // order of v: first receive, second receive, rx sync, tx sync
    task automatic set_pins(input logic [3:0] v);
        {rx_a, rx_b, rfs, tfs} <= v;
    endtask : set_pins

    // link clock runs only inside a frame and idles low between frames;
    // each half period is four pclk cycles, 64 ns in all
    task automatic burst(input int n);
        repeat (n) begin
            repeat (4) @(posedge pclk);
            sclk <= 1'b1;
            repeat (4) @(posedge pclk);
            sclk <= 1'b0;
        end
    endtask : burst
endmodule : serial_link_peer

/* File: testbench.sv */
// self-checking bench for the serial port pin multiplexer
`timescale 1ns/1ns
module testbench;
    import serial_port_pin_mux_pkg::*;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b1;
    logic [15:0] paddr   = 16'h0000;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic        tx_d    = 1'b0;
    logic        flag1   = 1'b0;
    logic        flag_o  = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, a_out, a_oe_n, b_out, b_oe_n, fs_out;
    logic        fs_oe_n, td_out, rx_d, rx_fs, tx_fs, s_rise, s_fall;
    logic        f_in, core_interrupt_zero_n, core_interrupt_one_n, a_pin, b_pin, fs_pin;
    int          err_count = 0;
    int          n_checks  = 0;
    int          rise_cnt  = 0;
    int          fall_cnt  = 0;

    serial_link_peer i_peer (
        .pclk (pclk)
    );
    // device drive wins the pin while its enable is low
    assign a_pin  = (a_oe_n === 1'b0) ? a_out : i_peer.rx_a;
    assign b_pin  = (b_oe_n === 1'b0) ? b_out : i_peer.rx_b;
    assign fs_pin = (fs_oe_n === 1'b0) ? fs_out : i_peer.rfs;

    serial_port_pin_mux i_dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .first_rx_in(a_pin), .first_rx_out(a_out), .first_rx_oe_n(a_oe_n),
        .second_rx_in(b_pin), .second_rx_out(b_out),
        .second_rx_oe_n(b_oe_n), .frame_sync_in(fs_pin),
        .frame_sync_out(fs_out), .frame_sync_oe_n(fs_oe_n),
        .tx_frame_sync_in(i_peer.tfs), .serial_clock_in(i_peer.sclk),
        .transmit_data_out(td_out), .sp_tx_data(tx_d),
        .core_flag_one(flag1), .core_flag_out(flag_o), .sp_rx_data(rx_d),
        .sp_rx_frame_sync(rx_fs), .sp_tx_frame_sync(tx_fs),
        .sp_sclk_rise(s_rise), .sp_sclk_fall(s_fall), .flag_input(f_in),
        .core_core_interrupt_zero_n(core_interrupt_zero_n), .core_core_interrupt_one_n(core_interrupt_one_n));

    always #4 pclk = ~pclk;

    always @(posedge pclk) begin
        if (s_rise === 1'b1) rise_cnt <= rise_cnt + 1;
        if (s_fall === 1'b1) fall_cnt <= fall_cnt + 1;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done

    task automatic chk_bit(input logic got, input logic exp, input string m);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t %s got %b exp %b", $time, m, got, exp);
        end
    endtask : chk_bit

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
                            input string m);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk_word

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [IDX_W-1:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            err_count++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, idx, d, r, e);
    endtask : wr

    task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [31:0] x,
                          input logic ex);
        logic [31:0] r;
        logic        e;
        apb(1'b0, idx, 32'h0000_0000, r, e);
        chk_word(r, x, "read data");
        chk_bit(e, ex, "slave error");
    endtask : rd_chk

    task automatic pins(input logic [3:0] v);
        i_peer.set_pins(v);
        repeat (6) @(posedge pclk);
    endtask : pins

    task automatic t_reset;
        rd_chk(MODE_CTRL_IDX, 32'h0000_0000, 1'b0);
        rd_chk(CORE_SYS_IDX, 32'h0000_0000, 1'b0);
        pins(4'b1000);
        chk_bit(rx_d, 1'b1, "first pin after reset");
        chk_bit(f_in, 1'b0, "flag input idle");
        rd_chk(14'h0001, 32'h0000_0000, 1'b1);
        wr(MODE_CTRL_IDX, 32'hffff_ffff);
        rd_chk(MODE_CTRL_IDX, 32'h0000_01ff, 1'b0);
        wr(MODE_CTRL_IDX, 32'h0000_0000);
    endtask : t_reset

    task automatic t_rx_select;
        tx_d <= 1'b1;
        pins(4'b0111);
        chk_bit(rx_d, 1'b0, "first pin chosen");
        chk_bit(rx_fs, 1'b1, "rx sync normal");
        chk_bit(tx_fs, 1'b1, "tx sync normal");
        chk_bit(td_out, 1'b1, "tx data normal");
        wr(MODE_CTRL_IDX, 32'h0000_0010);
        pins(4'b0100);
        chk_bit(rx_d, 1'b1, "second pin chosen");
        pins(4'b1000);
        chk_bit(rx_d, 1'b0, "second pin low");
    endtask : t_rx_select

    task automatic t_uart;
        wr(MODE_CTRL_IDX, 32'h0000_0030);
        flag1 <= 1'b1;
        pins(4'b0100);
        chk_bit(rx_fs, 1'b1, "sync joined to data");
        chk_bit(fs_oe_n, 1'b0, "flag drives sync pin");
        chk_bit(fs_out, 1'b1, "flag one high");
        flag1 <= 1'b0;
        pins(4'b0010);
        chk_bit(rx_fs, 1'b0, "sync joined low");
        chk_bit(fs_out, 1'b0, "flag one low");
        wr(MODE_CTRL_IDX, 32'h0000_0010);
        repeat (2) @(posedge pclk);
        chk_bit(fs_oe_n, 1'b1, "sync pin released");
    endtask : t_uart

    task automatic t_alt;
        wr(CORE_SYS_IDX, 32'h0000_0400);
        flag_o <= 1'b1;
        tx_d <= 1'b0;
        pins(4'b0101);
        chk_bit(f_in, 1'b1, "flag in second pin");
        chk_bit(rx_d, 1'b0, "rx data parked");
        chk_bit(td_out, 1'b1, "flag out on tx pin");
        chk_bit(core_interrupt_zero_n, 1'b0, "irq zero from rx sync");
        chk_bit(core_interrupt_one_n, 1'b1, "irq one from tx sync");
        chk_bit(tx_fs, 1'b0, "tx sync parked");
        wr(MODE_CTRL_IDX, 32'h0000_0000);
        pins(4'b1010);
        chk_bit(f_in, 1'b1, "flag in first pin");
        chk_bit(rx_fs, 1'b0, "rx sync parked");
        chk_bit(core_interrupt_zero_n, 1'b1, "irq zero high");
        chk_bit(core_interrupt_one_n, 1'b0, "irq one low");
        rd_chk(CORE_SYS_IDX, 32'h0000_0400, 1'b0);
        wr(CORE_SYS_IDX, 32'h0000_0200);
        pins(4'b1000);
        chk_bit(f_in, 1'b0, "other bit no alt");
        chk_bit(rx_d, 1'b1, "serial path back");
    endtask : t_alt

    task automatic t_sclk;
        int r0;
        int f0;
        wr(CORE_SYS_IDX, 32'h0000_0400);
        wr(PIN_SEL_IDX, 32'h0000_0000);
        r0 = rise_cnt;
        f0 = fall_cnt;
        i_peer.burst(5);
        repeat (6) @(posedge pclk);
        chk_word(rise_cnt - r0, 32'd5, "clock rises in alt");
        chk_word(fall_cnt - f0, 32'd5, "clock falls in alt");
        wr(PIN_SEL_IDX, 32'h0000_0008);
        i_peer.burst(3);
        repeat (6) @(posedge pclk);
        chk_word(rise_cnt - r0, 32'd5, "clock pin as gpio");
        wr(PIN_SEL_IDX, 32'h0000_0000);
        wr(CORE_SYS_IDX, 32'h0000_0000);
    endtask : t_sclk

    task automatic t_gpio;
        pins(4'b0000);
        wr(RX_GPIO_IDX, 32'h0000_000f);
        repeat (6) @(posedge pclk);
        chk_bit(a_oe_n, 1'b1, "selected pin not driven");
        chk_bit(b_oe_n, 1'b0, "spare pin driven");
        chk_bit(b_out, 1'b1, "spare pin value");
        chk_bit(a_out, 1'b1, "first pin drive value");
        rd_chk(RX_GPIO_IDX, 32'h0000_002f, 1'b0);
        wr(MODE_CTRL_IDX, 32'h0000_0010);
        repeat (2) @(posedge pclk);
        chk_bit(b_oe_n, 1'b1, "second now serial");
        chk_bit(a_oe_n, 1'b0, "first now gpio");
        wr(RX_GPIO_IDX, 32'h0000_0000);
    endtask : t_gpio

    // reset in mid-run must clear mode bits set before it
    task automatic t_mid_reset;
        wr(MODE_CTRL_IDX, 32'h0000_0030);
        wr(CORE_SYS_IDX, 32'h0000_0400);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(MODE_CTRL_IDX, 32'h0000_0000, 1'b0);
        rd_chk(CORE_SYS_IDX, 32'h0000_0000, 1'b0);
        chk_bit(fs_oe_n, 1'b1, "sync pin free after reset");
        chk_bit(f_in, 1'b0, "flag input idle after reset");
    endtask : t_mid_reset

    initial begin
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_rx_select();
        t_uart();
        t_alt();
        t_sclk();
        t_gpio();
        t_mid_reset();
        test_done();
    end
endmodule : testbench
